/* File: rsm_pkg.sv */
// Package for the reset and supply monitor controller: register offsets, fields, reset values, timing.
// Assumes a byte-wide special function register port and a 250 MHz system clock.
package rsm_pkg;
   localparam logic [7:0]  POR_STOP_CTRL_ADDR     = 8'h94;
   localparam logic [7:0]  IRQ_FLAG_REG_ADDR      = 8'h95;
   localparam logic [7:0]  SOFT_COMMAND_REG_ADDR  = 8'h97;
   localparam logic [7:0]  LVD_CTRL_ADDR          = 8'hbf;
   localparam logic [7:0]  AUX_CTRL_TWO_ADDR      = 8'hf7;
   localparam logic [7:0]  AUX_CTRL_ONE_ADDR      = 8'hf8;
   localparam logic [15:0] CONFIG_WORD_HIGH_ADDR  = 16'h7fff;
   localparam logic [7:0]  SOFT_RESET_CODE        = 8'h56;
   localparam logic [7:0]  LVD_FLAG_CLEAR_CODE    = 8'h7f;
   localparam logic [7:0]  POR_STOP_KEEP          = 8'h00;
   localparam logic [7:0]  POR_STOP_OFF           = 8'h01;
   localparam logic [7:0]  REG_RESET_VALUE        = 8'h00;
   localparam int          LOW_POWER_SAVE_BIT     = 5;
   localparam int          LV_RESET_DISABLE_BIT   = 3;
   localparam int          LV_DETECT_IRQ_EN_BIT   = 7;
   localparam int          LV_DETECT_FLAG_BIT     = 7;
   localparam int          EXT_PIN_RESET_OFF_BIT  = 6;
   localparam int          LV_RESET_LEVEL_LSB     = 3;
   localparam int          CONFIG_BYTES           = 6;
   localparam int          WARMUP_MS              = 40;
   localparam int          CLK_MHZ                = 250;
   localparam int          WARMUP_CYCLES          = WARMUP_MS * 1000 * CLK_MHZ;
   localparam int          RESET_STRETCH_CYCLES   = 4;

   typedef enum logic [2:0] {RSM_MODE_FAST, RSM_MODE_SLOW, RSM_MODE_IDLE,
                             RSM_MODE_HALT, RSM_MODE_STOP} rsm_mode_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rsm_sfr_req_type;

   typedef struct packed {
      logic       lvr_en;
      logic [2:0] lvr_level;
      logic       por_en;
      logic       lvd_en;
      logic [3:0] lvd_level;
   } rsm_analog_type;
endpackage

/* File: rsm_ctrl.sv */
// Reset and supply monitor controller: reset cause merging, warm-up and config load, LOW_VOLTAGE_RESET/LOW_VOLTAGE_DETECT control.
// Assumes analog comparators, the pin and the watchdog arrive asynchronously; config bytes come from a flash reader.
`timescale 1ns/100ps
// Notes on behaviour
// - Power-on, pin, software, watchdog and low-voltage causes each put the chip in reset.
// - Any reset returns every software register here to its default value; the high config byte reloads only on power-on.
// - Power-on holds reset 40 ms, then loads six config bytes, then releases.
// - A variant turns power-on reset off in Stop or Halt.
// - D variant: stop-control 00h keeps power-on reset in Stop/Halt, 01h disables it; code drops it there if LOW_VOLTAGE_RESET is off or power-save set.
// - Stop-control register is write-only, reads meaningless; only 00h or 01h written.
// - Three-bit config field picks LOW_VOLTAGE_RESET threshold 2.5 to 4.2 volts.
// - Power-save acts in Idle/Halt/Stop: 2.4V POR in Idle, off in Halt/Stop.
// - Four-bit field picks LOW_VOLTAGE_DETECT threshold 2.5V to 4.3V; 1011 and 1100 both 3.8V.
// - Low-voltage detection off in Idle, Halt and Stop.
// - Detect interrupt only when local and global enables are both set.
// - Hardware sets detect flag; writing 7Fh to the flag register clears it.
// - Writing 56h to the command register triggers a software reset.
// - Config high byte bit 6 at 0 enables pin reset, 1 ignores the pin.
module rsm_ctrl #(
   parameter int WARMUP_COUNT = rsm_pkg::WARMUP_CYCLES,
   parameter bit VARIANT_D    = 1'b1
) (
   input  wire logic                     clk_in,
   input  wire logic                     sys_rst_in,
   input  wire rsm_pkg::rsm_sfr_req_type sfr_req_in,
   output logic [7:0]                    sfr_rdata_out,
   input  wire rsm_pkg::rsm_mode_type    mode_in,
   input  wire logic                     por_in,
   input  wire logic                     ext_pin_reset_n_in,
   input  wire logic                     watchdog_reset_in,
   input  wire logic                     lv_reset_cmp_in,
   input  wire logic                     lv_detect_cmp_in,
   input  wire logic                     lv_detect_global_irq_en_in,
   input  wire logic                     cfg_valid_in,
   input  wire logic [7:0]               cfg_byte_in,
   output logic                          cfg_req_out,
   output logic [2:0]                    cfg_index_out,
   output logic                          chip_reset_out,
   output logic                          lv_detect_irq_out,
   output rsm_pkg::rsm_analog_type       analog_out
);
   import rsm_pkg::*;

   typedef enum logic [1:0] {ST_WARMUP, ST_LOAD, ST_RUN} rsm_state_type;

   function automatic logic hit(input rsm_sfr_req_type r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   logic [4:0]    sync1_q;
   logic [4:0]    sync2_q;
   rsm_state_type state_q;
   logic [31:0]   warm_cnt_q;
   logic [2:0]    cfg_cnt_q;
   logic [7:0]    config_word_high_q;
   logic [7:0]    aux_ctrl_one_q;
   logic [7:0]    aux_ctrl_two_q;
   logic [7:0]    lvd_ctrl_q;
   logic          por_stop_off_q;
   logic          lv_detect_flag_q;
   logic          soft_reset_q;
   logic [2:0]    stretch_q;
   logic          chip_reset_q;
   logic          cfg_req_q;
   logic          any_cause;
   logic          lowpower;
   logic          stopped;
   logic          por_active;
   logic          pin_rst;
   rsm_analog_type analog_d;

   // Two-stage synchronisers: por, pin, watchdog, lvr comparator, lvd comparator
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sync1_q <= 5'h1f;
         sync2_q <= 5'h1f;
      end else begin
         sync1_q <= {por_in, ~ext_pin_reset_n_in, watchdog_reset_in, lv_reset_cmp_in, lv_detect_cmp_in};
         sync2_q <= sync1_q;
      end
   end

   assign lowpower = (mode_in == RSM_MODE_IDLE) || (mode_in == RSM_MODE_HALT) || (mode_in == RSM_MODE_STOP);
   assign stopped  = (mode_in == RSM_MODE_HALT) || (mode_in == RSM_MODE_STOP);
   // Pin must already be seen low two cycles through the synchroniser
   assign pin_rst  = sync2_q[3] && !config_word_high_q[EXT_PIN_RESET_OFF_BIT];

   // Analog enables
   always_comb begin
      analog_d.lvr_level = config_word_high_q[LV_RESET_LEVEL_LSB +: 3];
      analog_d.lvd_level = lvd_ctrl_q[3:0];
      analog_d.lvd_en    = !lowpower;
      por_active = !stopped || (VARIANT_D && !por_stop_off_q);
      if (aux_ctrl_one_q[LV_RESET_DISABLE_BIT]) begin
         analog_d.lvr_en = 1'b0;
         analog_d.por_en = !stopped;
      end else if (lowpower && aux_ctrl_two_q[LOW_POWER_SAVE_BIT]) begin
         analog_d.lvr_en = 1'b0;
         analog_d.por_en = !stopped;
      end else begin
         analog_d.lvr_en = 1'b1;
         analog_d.por_en = por_active;
      end
   end

   // Cause merge; power-on cause also restarts warm-up
   assign any_cause = (sync2_q[4] && analog_d.por_en) || pin_rst || soft_reset_q || sync2_q[2]
                      || (sync2_q[1] && analog_d.lvr_en);

   // Reset output asserts the cycle after a cause, held a few cycles after it goes
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         stretch_q    <= 3'(RESET_STRETCH_CYCLES);
         chip_reset_q <= 1'b1;
      end else if (any_cause || state_q != ST_RUN) begin
         stretch_q    <= 3'(RESET_STRETCH_CYCLES);
         chip_reset_q <= 1'b1;
      end else if (stretch_q != 3'h0) begin
         stretch_q    <= stretch_q - 3'h1;
         chip_reset_q <= 1'b1;
      end else begin
         chip_reset_q <= 1'b0;
      end
   end

   // Power-on sequence: warm-up then configuration load
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || (sync2_q[4] && analog_d.por_en)) begin
         state_q    <= ST_WARMUP;
         warm_cnt_q <= 32'h0;
         cfg_cnt_q  <= 3'h0;
         cfg_req_q  <= 1'b0;
      end else begin
         case (state_q)
            ST_WARMUP: begin
               if (warm_cnt_q == 32'(WARMUP_COUNT - 1)) begin
                  state_q   <= ST_LOAD;
                  cfg_req_q <= 1'b1;
               end
               warm_cnt_q <= warm_cnt_q + 32'h1;
            end
            ST_LOAD: begin
               if (cfg_valid_in) begin
                  cfg_cnt_q <= cfg_cnt_q + 3'h1;
                  if (cfg_cnt_q == 3'(CONFIG_BYTES - 1)) begin
                     state_q   <= ST_RUN;
                     cfg_req_q <= 1'b0;
                  end
               end
            end
            ST_RUN: state_q <= ST_RUN;
            default: state_q <= ST_WARMUP;
         endcase
      end
   end

   // Last byte fetched is the high config byte at the top of memory
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         config_word_high_q <= REG_RESET_VALUE;
      end else if (state_q == ST_LOAD && cfg_valid_in && cfg_cnt_q == 3'(CONFIG_BYTES - 1)) begin
         config_word_high_q <= cfg_byte_in;
      end
   end

   // Software registers; any chip reset restores defaults
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || chip_reset_q) begin
         aux_ctrl_one_q <= REG_RESET_VALUE;
         aux_ctrl_two_q <= REG_RESET_VALUE;
         lvd_ctrl_q     <= REG_RESET_VALUE;
         por_stop_off_q <= 1'b0;
      end else begin
         if (hit(sfr_req_in, AUX_CTRL_ONE_ADDR)) begin
            aux_ctrl_one_q <= sfr_req_in.wdata;
         end
         if (hit(sfr_req_in, AUX_CTRL_TWO_ADDR)) begin
            aux_ctrl_two_q <= sfr_req_in.wdata;
         end
         if (hit(sfr_req_in, LVD_CTRL_ADDR)) begin
            lvd_ctrl_q <= {sfr_req_in.wdata[7], 3'h0, sfr_req_in.wdata[3:0]};
         end
         // Other codes are forbidden; they are ignored rather than guessed at
         if (hit(sfr_req_in, POR_STOP_CTRL_ADDR) && sfr_req_in.wdata == POR_STOP_OFF) begin
            por_stop_off_q <= 1'b1;
         end else if (hit(sfr_req_in, POR_STOP_CTRL_ADDR) && sfr_req_in.wdata == POR_STOP_KEEP) begin
            por_stop_off_q <= 1'b0;
         end
      end
   end

   // Software reset pulse and detect flag
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || chip_reset_q) begin
         soft_reset_q     <= 1'b0;
         lv_detect_flag_q <= 1'b0;
      end else begin
         soft_reset_q <= hit(sfr_req_in, SOFT_COMMAND_REG_ADDR) && sfr_req_in.wdata == SOFT_RESET_CODE;
         // Set wins over a simultaneous clear
         if (sync2_q[0] && analog_d.lvd_en) begin
            lv_detect_flag_q <= 1'b1;
         end else if (hit(sfr_req_in, IRQ_FLAG_REG_ADDR) && sfr_req_in.wdata == LVD_FLAG_CLEAR_CODE) begin
            lv_detect_flag_q <= 1'b0;
         end
      end
   end

   // Registered outputs and read data
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sfr_rdata_out     <= 8'h00;
         lv_detect_irq_out <= 1'b0;
         analog_out        <= '0;
      end else begin
         lv_detect_irq_out <= lv_detect_flag_q && lvd_ctrl_q[LV_DETECT_IRQ_EN_BIT]
                              && lv_detect_global_irq_en_in;
         analog_out        <= analog_d;
         case (sfr_req_in.addr)
            LVD_CTRL_ADDR:     sfr_rdata_out <= {lvd_ctrl_q[7], sync2_q[0] && analog_d.lvd_en, 2'h0,
                                                 lvd_ctrl_q[3:0]};
            AUX_CTRL_ONE_ADDR: sfr_rdata_out <= aux_ctrl_one_q;
            AUX_CTRL_TWO_ADDR: sfr_rdata_out <= aux_ctrl_two_q;
            IRQ_FLAG_REG_ADDR: sfr_rdata_out <= {lv_detect_flag_q, 7'h00};
            default:           sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   assign chip_reset_out = chip_reset_q;
   // Request level is kept in step with the state register so the reader never sees a stale cycle
   assign cfg_req_out    = cfg_req_q;
   assign cfg_index_out  = cfg_cnt_q;

   property p_soft_reset;
      @(posedge clk_in) disable iff (sys_rst_in)
      (hit(sfr_req_in, SOFT_COMMAND_REG_ADDR) && sfr_req_in.wdata == SOFT_RESET_CODE && !chip_reset_q)
         |-> ##2 chip_reset_out;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("Soft command did not reset");

   property p_irq_gate;
      @(posedge clk_in) disable iff (sys_rst_in)
      lv_detect_irq_out |-> $past(lv_detect_flag_q) && $past(lvd_ctrl_q[LV_DETECT_IRQ_EN_BIT])
                            && $past(lv_detect_global_irq_en_in);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("Detect irq without both enables");

   property p_lvd_off;
      @(posedge clk_in) disable iff (sys_rst_in)
      lowpower |=> !analog_out.lvd_en;
   endproperty
   a_lvd_off: assert property (p_lvd_off) else $error("Detect active in low power");

   property p_run_release;
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_q != ST_RUN) |=> chip_reset_out;
   endproperty
   a_run_release: assert property (p_run_release) else $error("Reset released before load");

   property p_pin;
      @(posedge clk_in) disable iff (sys_rst_in)
      pin_rst |=> chip_reset_out;
   endproperty
   a_pin: assert property (p_pin) else $error("Pin reset missed");

   property p_lvr_disable;
      @(posedge clk_in) disable iff (sys_rst_in)
      aux_ctrl_one_q[LV_RESET_DISABLE_BIT] |=> !analog_out.lvr_en;
   endproperty
   a_lvr_disable: assert property (p_lvr_disable) else $error("LOW_VOLTAGE_RESET still on when disabled");

   property p_flag_clear;
      @(posedge clk_in) disable iff (sys_rst_in)
      (hit(sfr_req_in, IRQ_FLAG_REG_ADDR) && sfr_req_in.wdata == LVD_FLAG_CLEAR_CODE
       && !(sync2_q[0] && analog_d.lvd_en)) |=> !lv_detect_flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("Detect flag not cleared");

   property p_save_stop;
      @(posedge clk_in) disable iff (sys_rst_in)
      (stopped && aux_ctrl_two_q[LOW_POWER_SAVE_BIT]) |=> !analog_out.por_en && !analog_out.lvr_en;
   endproperty
   a_save_stop: assert property (p_save_stop) else $error("Supervision on in stop with save");
endmodule

/* File: rsm_far_model.sv */
// Far-side model: supply comparators and the flash reader feeding config bytes.
// Assumes the bench sets comparator levels and the high config byte; one clock.
`timescale 1ns/100ps
module rsm_far_model (
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       cfg_req_in,
   input  wire logic [2:0] cfg_index_in,
   input  wire logic       slow_in,
   input  wire logic [7:0] cfg_high_in,
   input  wire logic [2:0] cmp_set_in,
   output logic            por_out,
   output logic            lv_reset_out,
   output logic            lv_detect_out,
   output logic            cfg_valid_out,
   output logic [7:0]      cfg_byte_out
);
   logic [1:0] wait_q;
   assign {por_out, lv_reset_out, lv_detect_out} = cmp_set_in;
   // Bytes follow one at a time while the request is held; slow mode adds wait states like a busy flash
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cfg_req_in) begin
         wait_q        <= 2'h0;
         cfg_valid_out <= 1'b0;
      end else if (cfg_valid_out) begin
         wait_q        <= slow_in ? 2'h3 : 2'h0;
         cfg_valid_out <= 1'b0;
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else begin
         cfg_valid_out <= 1'b1;
      end
   end
   // Junk between transfers so a stale sample cannot pass
   always_ff @(posedge clk_in) begin
      if (!cfg_valid_out && cfg_req_in && !sys_rst_in && wait_q == 2'h0)
         cfg_byte_out <= (cfg_index_in == 3'h5) ? cfg_high_in : {5'h0, cfg_index_in} ^ 8'ha5;
      else
         cfg_byte_out <= ~cfg_byte_out;
   end
endmodule

/* File: test_reset_and_supply_monitor_ctrl.sv */
// Self-checking bench for the reset and supply monitor controller.
// Assumes rsm_pkg, rsm_ctrl and rsm_far_model; short warm-up keeps the run brief.
`timescale 1ns/100ps
module test_reset_and_supply_monitor_ctrl;
   import rsm_pkg::*;
   logic            clk_in, sys_rst_in, pin_n, wdog, gie, slow, cfg_valid, cfg_req, chip_rst, irq;
   logic            por, lvr_cmp, lvd_cmp;
   logic [7:0]      rdata, cfg_byte, cfg_high;
   logic [2:0]      cfg_idx, cmp_set;
   rsm_sfr_req_type req;
   rsm_mode_type    mode;
   rsm_analog_type  ana;
   int              failures, cmp_count;

   rsm_ctrl #(.WARMUP_COUNT(20), .VARIANT_D(1'b1)) i_rsm_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .sfr_req_in(req), .sfr_rdata_out(rdata), .mode_in(mode), .por_in(por), .ext_pin_reset_n_in(pin_n),
      .watchdog_reset_in(wdog), .lv_reset_cmp_in(lvr_cmp), .lv_detect_cmp_in(lvd_cmp),
      .lv_detect_global_irq_en_in(gie), .cfg_valid_in(cfg_valid), .cfg_byte_in(cfg_byte),
      .cfg_req_out(cfg_req), .cfg_index_out(cfg_idx), .chip_reset_out(chip_rst),
      .lv_detect_irq_out(irq), .analog_out(ana));
   rsm_far_model i_rsm_far_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_req_in(cfg_req),
      .cfg_index_in(cfg_idx), .slow_in(slow), .cfg_high_in(cfg_high), .cmp_set_in(cmp_set),
      .por_out(por), .lv_reset_out(lvr_cmp), .lv_detect_out(lvd_cmp), .cfg_valid_out(cfg_valid),
      .cfg_byte_out(cfg_byte));

   task automatic wrap_up();
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      settle(1);
      req.wr = 1'b0;
      settle(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      req.addr = a;
      settle(1);
      chk(what, exp, rdata);
   endtask
   task automatic wait_run();
      int n;
      n = 0;
      while (chip_rst !== 1'b0 && n < 400) begin
         settle(1);
         n++;
      end
      chk("reset release", 8'h0, 8'(chip_rst));
   endtask
   task automatic hit(input string what);
      int n;
      n = 0;
      while (chip_rst !== 1'b1 && n < 12) begin
         settle(1);
         n++;
      end
      chk(what, 8'h1, 8'(chip_rst));
      wait_run();
   endtask
   task automatic pulse_pin();
      pin_n = 1'b0;
      settle(4);
      pin_n = 1'b1;
   endtask
   task automatic mode_chk(input rsm_mode_type m, input string what, input logic [7:0] exp, input int sel);
      mode = m;
      settle(4);
      chk(what, exp, 8'(sel == 0 ? ana.lvr_en : sel == 1 ? ana.por_en : ana.lvd_en));
   endtask

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge clk_in);
      failures++;
      wrap_up();
   end
   initial begin
      int seen;
      sys_rst_in = 1'b1;
      req = '0;
      mode = RSM_MODE_FAST;
      {pin_n, wdog, gie, slow, cmp_set, cfg_high} = {1'b1, 3'h0, 3'h0, 8'h28};
      settle(8);
      sys_rst_in = 1'b0;
      wait_run();
      chk("lvr level", 8'h5, 8'(ana.lvr_level));
      rd(LVD_CTRL_ADDR, REG_RESET_VALUE, "detect reg");
      rd(AUX_CTRL_TWO_ADDR, REG_RESET_VALUE, "aux two");
      rd(AUX_CTRL_ONE_ADDR, REG_RESET_VALUE, "aux one");
      rd(8'h90, 8'h00, "unmapped");
      wr(LVD_CTRL_ADDR, 8'h8b);
      chk("lvd level", 8'hb, 8'(ana.lvd_level));
      mode_chk(RSM_MODE_FAST, "lvd on", 8'h1, 2);
      mode_chk(RSM_MODE_HALT, "lvd off", 8'h0, 2);
      mode_chk(RSM_MODE_FAST, "lvd back", 8'h1, 2);
      mode_chk(RSM_MODE_SLOW, "lvd slow", 8'h1, 2);
      cmp_set = 3'b001;
      settle(6);
      rd(LVD_CTRL_ADDR, 8'hcb, "detect status");
      chk("irq no global", 8'h0, 8'(irq));
      gie = 1'b1;
      settle(3);
      chk("irq both", 8'h1, 8'(irq));
      cmp_set = 3'b000;
      settle(6);
      chk("irq held", 8'h1, 8'(irq));
      wr(IRQ_FLAG_REG_ADDR, LVD_FLAG_CLEAR_CODE);
      chk("irq cleared", 8'h0, 8'(irq));
      wr(AUX_CTRL_TWO_ADDR, 8'h20);
      mode_chk(RSM_MODE_IDLE, "psave idle", 8'h0, 0);
      mode_chk(RSM_MODE_HALT, "psave halt", 8'h0, 1);
      mode_chk(RSM_MODE_FAST, "psave fast", 8'h1, 0);
      wr(AUX_CTRL_TWO_ADDR, 8'h00);
      mode_chk(RSM_MODE_IDLE, "no psave idle", 8'h1, 0);
      wr(AUX_CTRL_ONE_ADDR, 8'h08);
      mode_chk(RSM_MODE_FAST, "lvr off", 8'h0, 0);
      mode_chk(RSM_MODE_FAST, "por sub", 8'h1, 1);
      mode_chk(RSM_MODE_STOP, "por sub stop", 8'h0, 1);
      wr(AUX_CTRL_ONE_ADDR, 8'h00);
      wr(POR_STOP_CTRL_ADDR, POR_STOP_OFF);
      mode_chk(RSM_MODE_STOP, "por stop off", 8'h0, 1);
      wr(POR_STOP_CTRL_ADDR, 8'h03);
      mode_chk(RSM_MODE_STOP, "por bad value", 8'h0, 1);
      wr(POR_STOP_CTRL_ADDR, POR_STOP_KEEP);
      mode_chk(RSM_MODE_STOP, "por stop keep", 8'h1, 1);
      rd(POR_STOP_CTRL_ADDR, 8'h00, "stop ctrl read");
      mode = RSM_MODE_FAST;
      wr(SOFT_COMMAND_REG_ADDR, 8'h55);
      chk("no soft reset", 8'h0, 8'(chip_rst));
      wr(LVD_CTRL_ADDR, 8'h05);
      wr(SOFT_COMMAND_REG_ADDR, SOFT_RESET_CODE);
      hit("soft reset");
      rd(LVD_CTRL_ADDR, REG_RESET_VALUE, "after reset");
      pulse_pin();
      hit("pin reset");
      wdog = 1'b1;
      settle(3);
      wdog = 1'b0;
      hit("watchdog reset");
      cmp_set = 3'b010;
      settle(3);
      cmp_set = 3'b000;
      hit("lvr reset");
      cfg_high = 8'h70;
      slow = 1'b1;
      cmp_set = 3'b100;
      settle(3);
      cmp_set = 3'b000;
      hit("power on reset");
      chk("lvr level reload", 8'h6, 8'(ana.lvr_level));
      pulse_pin();
      seen = 0;
      repeat (12) begin
         settle(1);
         seen = seen | int'(chip_rst === 1'b1);
      end
      chk("pin ignored", 8'h0, 8'(seen));
      wrap_up();
   end
endmodule
